// [ppf_framer.sv]
// Pulse-input payload framer: builds two telegrams per format.
// Assumes meter values are stable in the cycle start is taken, and a
// byte-wide valid/ready sink that accepts the finished telegrams.
`timescale 1ns/1ps
`default_nettype none

module ppf_framer (
    // Clock and reset
    input  wire logic               clk_sys,
    input  wire logic               rst_n,
    // Meter register side
    input  wire logic               start,
    input  wire logic               fmt_ext,
    input  wire ppf_pkg::ppf_meter_t meter,
    output logic                    busy,
    // Uplink byte stream
    output logic                    tx_valid,
    input  wire logic               tx_ready,
    output ppf_pkg::ppf_byte_t      tx_byte
);

    // ========================================================================
    // Reset release synchroniser
    logic rst_meta_reg;
    logic rst_sync_reg;

    // Async assert, release after two edges
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end
        else
        begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end

    // ========================================================================
    // State
    ppf_pkg::ppf_state_t state_reg, state_next;
    logic                tel2_reg, tel2_next;
    logic                ext_reg, ext_next;
    logic [5:0]          idx_reg, idx_next;
    ppf_pkg::ppf_meter_t snap_reg, snap_next;
    logic                valid_reg, valid_next;
    ppf_pkg::ppf_byte_t  out_reg, out_next;

    // ========================================================================
    // Record list for the telegram in progress
    ppf_pkg::ppf_rec_t recs [ppf_pkg::NUM_RECS];
    logic [31:0]       info_word;
    logic [7:0]        pulse_vif;
    logic [2:0]        nrg_hlen;
    logic [2:0]        trf_hlen;
    logic [31:0]       nrg_hdr;

    // Header variants shared by several records
    always_comb
    begin
        // Narrow flag set widened to 32 bits
        info_word = snap_reg.info_wide ? snap_reg.info
                                       : {ppf_pkg::INFO_HI_ZERO, snap_reg.info[15:0]};
        // Pulse coding follows meter interpretation
        pulse_vif = snap_reg.pulse_is_energy ? ppf_pkg::VIF_PULSE_NRG : ppf_pkg::VIF_PULSE_VOL;
        nrg_hlen  = snap_reg.energy_vife_en ? ppf_pkg::LEN_H3 : ppf_pkg::LEN_H2;
        trf_hlen  = snap_reg.energy_vife_en ? ppf_pkg::LEN_H4 : ppf_pkg::LEN_H3;
        nrg_hdr   = {8'h00, snap_reg.energy_vife, snap_reg.energy_vif, ppf_pkg::DIF_INT32};
    end

    // Field order per format and telegram
    always_comb
    begin
        for (int k = 0; k < ppf_pkg::NUM_RECS; k++)
            recs[k] = '0;
        // Identifier byte opens every telegram
        // Second telegram carries its own code
        recs[0] = ppf_pkg::mk_rec(3'h1, {24'h00_0000,
                  tel2_reg ? ppf_pkg::MSG_ID_TEL2 : ppf_pkg::MSG_ID_TEL1}, 3'h0, 32'h0000_0000);
        // Packed calendar word follows the identifier
        recs[1] = ppf_pkg::mk_rec(ppf_pkg::LEN_H2, {16'h0000, ppf_pkg::VIF_DATE_TIME,
                  ppf_pkg::DIF_INT32}, ppf_pkg::LEN_D4, ppf_pkg::pack_time(snap_reg.dt));
        // Meter ID repeated in both telegrams
        recs[2] = ppf_pkg::mk_rec(ppf_pkg::LEN_H2, {16'h0000, ppf_pkg::VIF_METER_ID,
                  ppf_pkg::DIF_BCD8}, ppf_pkg::LEN_D4, snap_reg.id_bcd);
        if (!tel2_reg)
        begin
            // Basic and extended share the first fields
            recs[3] = ppf_pkg::mk_rec(nrg_hlen, nrg_hdr, ppf_pkg::LEN_D4, snap_reg.energy);
            recs[4] = ppf_pkg::mk_rec(ppf_pkg::LEN_H2, {16'h0000, snap_reg.volume_vif,
                      ppf_pkg::DIF_INT32}, ppf_pkg::LEN_D4, snap_reg.volume);
            recs[5] = ppf_pkg::mk_rec(ppf_pkg::LEN_H2, {16'h0000, snap_reg.power_vif,
                      ppf_pkg::DIF_INT16}, ppf_pkg::LEN_D2, {16'h0000, snap_reg.power});
            if (!ext_reg)
            begin
                // Flow then both temperatures
                recs[6] = ppf_pkg::mk_rec(ppf_pkg::LEN_H2, {16'h0000, snap_reg.flow_vif,
                          ppf_pkg::DIF_INT16}, ppf_pkg::LEN_D2, {16'h0000, snap_reg.flow});
                recs[7] = ppf_pkg::mk_rec(ppf_pkg::LEN_H2, {16'h0000, snap_reg.forward_vif,
                          ppf_pkg::DIF_INT16}, ppf_pkg::LEN_D2,
                          {16'h0000, snap_reg.forward_temperature});
                recs[8] = ppf_pkg::mk_rec(ppf_pkg::LEN_H2, {16'h0000, snap_reg.return_vif,
                          ppf_pkg::DIF_INT16}, ppf_pkg::LEN_D2,
                          {16'h0000, snap_reg.return_temperature});
            end
            else
            begin
                // Temperatures then info, flow dropped
                recs[6] = ppf_pkg::mk_rec(ppf_pkg::LEN_H2, {16'h0000, snap_reg.forward_vif,
                          ppf_pkg::DIF_INT16}, ppf_pkg::LEN_D2,
                          {16'h0000, snap_reg.forward_temperature});
                recs[7] = ppf_pkg::mk_rec(ppf_pkg::LEN_H2, {16'h0000, snap_reg.return_vif,
                          ppf_pkg::DIF_INT16}, ppf_pkg::LEN_D2,
                          {16'h0000, snap_reg.return_temperature});
                recs[8] = ppf_pkg::mk_rec(ppf_pkg::LEN_H3, {8'h00, ppf_pkg::VIFE_INFO,
                          ppf_pkg::VIF_INFO, ppf_pkg::DIF_INT32}, ppf_pkg::LEN_D4, info_word);
            end
        end
        else if (!ext_reg)
        begin
            // Input A, one DIFE, sub-unit 1
            recs[3] = ppf_pkg::mk_rec(ppf_pkg::LEN_H3, {8'h00, pulse_vif, ppf_pkg::DIFE_SUBUNIT1,
                      ppf_pkg::DIF_EXT_INT32}, ppf_pkg::LEN_D4, snap_reg.pulse_a);
            // Input B, two DIFEs, sub-unit 2
            recs[4] = ppf_pkg::mk_rec(ppf_pkg::LEN_H4, {pulse_vif, ppf_pkg::DIFE_SUB2_HIGH,
                      ppf_pkg::DIFE_SUB2_LOW, ppf_pkg::DIF_EXT_INT32}, ppf_pkg::LEN_D4,
                      snap_reg.pulse_b);
            // Operating hours after the pulse inputs
            recs[5] = ppf_pkg::mk_rec(ppf_pkg::LEN_H2, {16'h0000, ppf_pkg::VIF_OP_HOURS,
                      ppf_pkg::DIF_INT32}, ppf_pkg::LEN_D4, snap_reg.op_hours);
            // Info closes the basic second telegram
            recs[6] = ppf_pkg::mk_rec(ppf_pkg::LEN_H3, {8'h00, ppf_pkg::VIFE_INFO,
                      ppf_pkg::VIF_INFO, ppf_pkg::DIF_INT32}, ppf_pkg::LEN_D4, info_word);
        end
        else
        begin
            // Tariffs between meter ID and pulses
            recs[3] = ppf_pkg::mk_rec(trf_hlen, {snap_reg.energy_vife, snap_reg.energy_vif,
                      ppf_pkg::DIFE_TARIFF2, ppf_pkg::DIF_EXT_INT32}, ppf_pkg::LEN_D4,
                      snap_reg.tariff2);
            recs[4] = ppf_pkg::mk_rec(trf_hlen, {snap_reg.energy_vife, snap_reg.energy_vif,
                      ppf_pkg::DIFE_TARIFF3, ppf_pkg::DIF_EXT_INT32}, ppf_pkg::LEN_D4,
                      snap_reg.tariff3);
            // Input A record, sub-unit 1
            recs[5] = ppf_pkg::mk_rec(ppf_pkg::LEN_H3, {8'h00, pulse_vif, ppf_pkg::DIFE_SUBUNIT1,
                      ppf_pkg::DIF_EXT_INT32}, ppf_pkg::LEN_D4, snap_reg.pulse_a);
            // Input B record, sub-unit 2
            recs[6] = ppf_pkg::mk_rec(ppf_pkg::LEN_H4, {pulse_vif, ppf_pkg::DIFE_SUB2_HIGH,
                      ppf_pkg::DIFE_SUB2_LOW, ppf_pkg::DIF_EXT_INT32}, ppf_pkg::LEN_D4,
                      snap_reg.pulse_b);
        end
    end

    // ========================================================================
    // Byte selection by running offset
    logic [7:0] cur_byte;
    logic [5:0] total_len;

    // Records already hold data low byte first
    always_comb
    begin
        logic [5:0] off;
        off       = '0;
        cur_byte  = '0;
        for (int k = 0; k < ppf_pkg::NUM_RECS; k++)
        begin
            if (idx_reg >= off && idx_reg < off + {2'b00, recs[k].len})
                cur_byte = recs[k].b[3'(idx_reg - off)];
            off = off + {2'b00, recs[k].len};
        end
        total_len = off;
    end

    // ========================================================================
    // Sequencer and output register, next values
    logic load;
    logic last_byte;

    always_comb
    begin
        load       = !valid_reg || tx_ready;
        last_byte  = (idx_reg == total_len - ppf_pkg::IDX_ONE);
        state_next = state_reg;
        tel2_next  = tel2_reg;
        ext_next   = ext_reg;
        idx_next   = idx_reg;
        snap_next  = snap_reg;
        valid_next = valid_reg;
        out_next   = out_reg;
        unique case (state_reg)
            ppf_pkg::ST_IDLE:
            begin
                if (load)
                    valid_next = 1'b0;
                // Snapshot keeps both telegrams consistent
                if (start)
                begin
                    state_next = ppf_pkg::ST_SEND;
                    tel2_next  = 1'b0;
                    ext_next   = fmt_ext;
                    idx_next   = '0;
                    snap_next  = meter;
                end
            end
            ppf_pkg::ST_SEND:
            begin
                if (load)
                begin
                    valid_next    = 1'b1;
                    out_next.data = cur_byte;
                    out_next.sof  = (idx_reg == '0);
                    out_next.eof  = last_byte;
                    out_next.tel2 = tel2_reg;
                    idx_next      = idx_reg + ppf_pkg::IDX_ONE;
                    if (last_byte)
                    begin
                        idx_next = '0;
                        // First telegram done, second follows
                        if (!tel2_reg)
                            tel2_next = 1'b1;
                        else
                            state_next = ppf_pkg::ST_IDLE;
                    end
                end
            end
        endcase
    end

    // Register everything, reset to idle
    always_ff @(posedge clk_sys or negedge rst_sync_reg)
    begin
        if (!rst_sync_reg)
        begin
            state_reg <= ppf_pkg::ST_IDLE;
            tel2_reg  <= 1'b0;
            ext_reg   <= 1'b0;
            idx_reg   <= '0;
            snap_reg  <= '0;
            valid_reg <= 1'b0;
            out_reg   <= '0;
        end
        else
        begin
            state_reg <= state_next;
            tel2_reg  <= tel2_next;
            ext_reg   <= ext_next;
            idx_reg   <= idx_next;
            snap_reg  <= snap_next;
            valid_reg <= valid_next;
            out_reg   <= out_next;
        end
    end

    // ========================================================================
    // Outputs
    assign busy     = (state_reg != ppf_pkg::ST_IDLE);
    assign tx_valid = valid_reg;
    assign tx_byte  = out_reg;

endmodule // ppf_framer

`default_nettype wire

// [ppf_framer_asserts.sv]
// Port-level assertions for the pulse payload framer.
// Assumes it is bound to ppf_framer; one clock domain, rst_n as reset.
`timescale 1ns/1ps
`default_nettype none

module ppf_framer_asserts (
    // Clock and reset
    input  wire logic                clk_sys,
    input  wire logic                rst_n,
    // Meter register side
    input  wire logic                start,
    input  wire logic                busy,
    // Uplink byte stream
    input  wire logic                tx_valid,
    input  wire logic                tx_ready,
    input  wire ppf_pkg::ppf_byte_t  tx_byte
);
    // ========================================================================
    // Common clocking and reset
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    // ========================================================================
    // Telegram framing
    chk_first_id: assert property (tx_valid && tx_byte.sof && !tx_byte.tel2 |-> tx_byte.data == 8'h1C)
        else $error("first telegram identifier wrong");
    chk_second_id: assert property (tx_valid && tx_byte.sof && tx_byte.tel2 |-> tx_byte.data == 8'h1D)
        else $error("second telegram identifier wrong");
    chk_tel_chain: assert property (tx_valid && tx_ready && tx_byte.eof && !tx_byte.tel2
        |=> tx_valid && tx_byte.sof && tx_byte.tel2)
        else $error("second telegram does not follow the first");
    chk_time_hdr: assert property (tx_valid && tx_ready && tx_byte.sof |=> tx_valid && tx_byte.data == 8'h04)
        else $error("time record header missing after identifier");
    // Handshake: a stalled byte must not move
    chk_stall_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_byte))
        else $error("byte changed while stalled");
    // Request and completion timing
    chk_start_busy: assert property (start && !busy |=> busy)
        else $error("start not taken");
    chk_first_byte: assert property ($rose(busy) && !tx_valid |=> tx_valid && tx_byte.sof && !tx_byte.tel2)
        else $error("first byte late");
    chk_busy_end: assert property ($fell(busy) |-> $past(tx_valid) && $past(tx_byte.tel2))
        else $error("busy dropped before second telegram");
    chk_valid_cause: assert property ($rose(tx_valid) |-> $past(busy))
        else $error("byte offered without a message");
endmodule // ppf_framer_asserts

bind ppf_framer ppf_framer_asserts i_chk (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .start    (start),
    .busy     (busy),
    .tx_valid (tx_valid),
    .tx_ready (tx_ready),
    .tx_byte  (tx_byte)
);

`default_nettype wire

// [ppf_pkg.sv]
// Shared types and constants for the pulse-input payload framer.
// Assumes byte-oriented M-Bus style data records, little-endian data fields.
package ppf_pkg;

    // ========================================================================
    // Message identifiers
    localparam logic [7:0] MSG_ID_TEL1 = 8'h1C;
    localparam logic [7:0] MSG_ID_TEL2 = 8'h1D;

    // ========================================================================
    // Record header bytes (DIF, DIFE, VIF, VIFE)
    localparam logic [7:0] DIF_INT32      = 8'h04;
    localparam logic [7:0] DIF_INT16      = 8'h02;
    localparam logic [7:0] DIF_BCD8       = 8'h0C;
    localparam logic [7:0] DIF_EXT_INT32  = 8'h84;
    localparam logic [7:0] DIFE_TARIFF2   = 8'h20;
    localparam logic [7:0] DIFE_TARIFF3   = 8'h30;
    localparam logic [7:0] DIFE_SUBUNIT1  = 8'h40;
    localparam logic [7:0] DIFE_SUB2_LOW  = 8'h80;
    localparam logic [7:0] DIFE_SUB2_HIGH = 8'h40;
    localparam logic [7:0] VIF_DATE_TIME  = 8'h6D;
    localparam logic [7:0] VIF_METER_ID   = 8'h78;
    localparam logic [7:0] VIF_OP_HOURS   = 8'h22;
    localparam logic [7:0] VIF_INFO       = 8'hFD;
    localparam logic [7:0] VIFE_INFO      = 8'h17;
    localparam logic [7:0] VIF_PULSE_VOL  = 8'h14;
    localparam logic [7:0] VIF_PULSE_NRG  = 8'h07;

    // ========================================================================
    // Record sizing
    localparam int            REC_BYTES = 8;
    localparam int            NUM_RECS  = 9;
    localparam logic [5:0]    IDX_ONE   = 6'h01;
    localparam logic [2:0]    LEN_D4    = 3'h4;
    localparam logic [2:0]    LEN_D2    = 3'h2;
    localparam logic [2:0]    LEN_H2    = 3'h2;
    localparam logic [2:0]    LEN_H3    = 3'h3;
    localparam logic [2:0]    LEN_H4    = 3'h4;
    localparam logic [15:0]   INFO_HI_ZERO = 16'h0000;

    // ========================================================================
    // Types
    typedef enum logic {ST_IDLE, ST_SEND} ppf_state_t;

    typedef struct packed {
        logic [3:0]                len;
        logic [REC_BYTES-1:0][7:0] b;   // b[0] goes out first
    } ppf_rec_t;

    typedef struct packed {
        logic [6:0] year;
        logic [3:0] month;
        logic [4:0] day;
        logic       summer;
        logic [4:0] hour;
        logic       invalid;
        logic [5:0] minute;
    } ppf_time_t;

    typedef struct packed {
        ppf_time_t   dt;
        logic [31:0] id_bcd;
        logic [31:0] energy;
        logic [7:0]  energy_vif;
        logic [7:0]  energy_vife;
        logic        energy_vife_en;
        logic [31:0] tariff2;
        logic [31:0] tariff3;
        logic [31:0] volume;
        logic [7:0]  volume_vif;
        logic [15:0] power;
        logic [7:0]  power_vif;
        logic [15:0] flow;
        logic [7:0]  flow_vif;
        logic [15:0] forward_temperature;
        logic [7:0]  forward_vif;
        logic [15:0] return_temperature;
        logic [7:0]  return_vif;
        logic [31:0] pulse_a;
        logic [31:0] pulse_b;
        logic        pulse_is_energy;
        logic [31:0] op_hours;
        logic [31:0] info;
        logic        info_wide;
    } ppf_meter_t;

    typedef struct packed {
        logic [7:0] data;
        logic       sof;
        logic       eof;
        logic       tel2;
    } ppf_byte_t;

    // Build one record: header bytes (low byte first) then data, LSB first
    function automatic ppf_rec_t mk_rec(input logic [2:0]  hlen,
                                        input logic [31:0] hdr,
                                        input logic [2:0]  dlen,
                                        input logic [31:0] dat);
        ppf_rec_t r;
        r.len = {1'b0, hlen} + {1'b0, dlen};
        r.b   = '0;
        for (int i = 0; i < REC_BYTES; i++)
        begin
            if (i < int'(hlen))
                r.b[i] = hdr[8*(i%4) +: 8];
            else if (i < int'(hlen) + int'(dlen))
                r.b[i] = dat[8*((i-int'(hlen))%4) +: 8];
        end
        return r;
    endfunction

    // Pack the calendar fields into the 32-bit date/time word
    function automatic logic [31:0] pack_time(input ppf_time_t t);
        return {t.year[6:3], t.month, t.year[2:0], t.day, t.summer, 2'b00,
                t.hour, t.invalid, 1'b0, t.minute};
    endfunction

endpackage

// [ppf_sink_model.sv]
// Uplink sink model standing in for the radio transmitter.
// Assumes the framer's valid/ready byte stream on clk_sys.
`timescale 1ns/1ps
`default_nettype none

module ppf_sink_model (
    // Clock and reset
    input  wire logic clk_sys,
    input  wire logic rst_n,
    // Pacing chosen by the bench
    input  wire logic slow,
    // Uplink byte stream
    input  wire logic tx_valid,
    output logic      tx_ready
);
    logic [1:0] ph_reg;

    // Slow mode takes one byte in three, mimicking a draining radio buffer
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ph_reg   <= 2'h0;
            tx_ready <= 1'b0;
        end
        else
        begin
            ph_reg   <= (ph_reg == 2'h2 || !tx_valid) ? 2'h0 : ph_reg + 2'h1;
            tx_ready <= !slow || (ph_reg == 2'h1);
        end
    end
endmodule // ppf_sink_model

`default_nettype wire

// [tb.sv]
// Self-checking bench for the pulse payload framer.
// Assumes ppf_pkg, the framer, its bound checker and the sink model.
`timescale 1ns/1ps
`default_nettype none

module tb;
    logic                clk_sys = 1'b0;
    logic                rst_n   = 1'b0;
    logic                start   = 1'b0;
    logic                fmt_ext = 1'b0;
    logic                slow    = 1'b0;
    ppf_pkg::ppf_meter_t meter   = '0;
    logic                busy;
    logic                tx_valid;
    logic                tx_ready;
    ppf_pkg::ppf_byte_t  tx_byte;
    int                  n_errors  = 0;
    int                  tests_run = 0;
    logic [7:0]          exp_q[$];
    ppf_pkg::ppf_byte_t  got_q[$];

    // ========================================================================
    // Clock, design and far-side model
    always #5 clk_sys = ~clk_sys;

    ppf_framer i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .start(start), .fmt_ext(fmt_ext), .meter(meter),
                      .busy(busy), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_byte(tx_byte));
    ppf_sink_model i_sink (.clk_sys(clk_sys), .rst_n(rst_n), .slow(slow), .tx_valid(tx_valid),
                           .tx_ready(tx_ready));

    // Capture every accepted byte
    always @(posedge clk_sys)
        if (tx_valid === 1'b1 && tx_ready === 1'b1)
            got_q.push_back(tx_byte);

    // ========================================================================
    // Helpers
    task automatic test_done;
        $display("checks=%0d mismatches=%0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
            n_errors++;
        end
    endtask

    task automatic timeout;
        $display("[FAIL] t=%0t got=%h exp=%h", $time, 32'h0000_0000, 32'h0000_0001);
        n_errors++;
        test_done();
    endtask

    // Push header bytes then data bytes, low byte first
    task automatic rec(input int hn, input logic [31:0] hdr, input int dn, input logic [31:0] dat);
        for (int i = 0; i < hn; i++)
            exp_q.push_back(hdr[8*i +: 8]);
        for (int i = 0; i < dn; i++)
            exp_q.push_back(dat[8*i +: 8]);
    endtask

    // Expected payload of both telegrams from the current snapshot
    task automatic build_exp(output int n1);
        logic [31:0] tw;
        logic [31:0] inf;
        logic [7:0]  pv;
        int          eh;
        tw  = {meter.dt.year[6:3], meter.dt.month, meter.dt.year[2:0], meter.dt.day, meter.dt.summer,
               2'b00, meter.dt.hour, meter.dt.invalid, 1'b0, meter.dt.minute};
        inf = meter.info_wide ? meter.info : {16'h0000, meter.info[15:0]};
        pv  = meter.pulse_is_energy ? 8'h07 : 8'h14;
        eh  = meter.energy_vife_en ? 1 : 0;
        exp_q.delete();
        rec(1, 32'h0000_001C, 0, 32'h0000_0000);
        rec(2, 32'h0000_6D04, 4, tw);
        rec(2, 32'h0000_780C, 4, meter.id_bcd);
        rec(2 + eh, {8'h00, meter.energy_vife, meter.energy_vif, 8'h04}, 4, meter.energy);
        rec(2, {16'h0000, meter.volume_vif, 8'h04}, 4, meter.volume);
        rec(2, {16'h0000, meter.power_vif, 8'h02}, 2, {16'h0000, meter.power});
        if (!fmt_ext)
            rec(2, {16'h0000, meter.flow_vif, 8'h02}, 2, {16'h0000, meter.flow});
        rec(2, {16'h0000, meter.forward_vif, 8'h02}, 2, {16'h0000, meter.forward_temperature});
        rec(2, {16'h0000, meter.return_vif, 8'h02}, 2, {16'h0000, meter.return_temperature});
        if (fmt_ext)
            rec(3, 32'h0017_FD04, 4, inf);
        n1 = exp_q.size();
        // second telegram repeats time and identity
        rec(1, 32'h0000_001D, 0, 32'h0000_0000);
        rec(2, 32'h0000_6D04, 4, tw);
        rec(2, 32'h0000_780C, 4, meter.id_bcd);
        // tariffs only in the extended format
        if (fmt_ext)
        begin
            rec(3 + eh, {meter.energy_vife, meter.energy_vif, 8'h20, 8'h84}, 4, meter.tariff2);
            rec(3 + eh, {meter.energy_vife, meter.energy_vif, 8'h30, 8'h84}, 4, meter.tariff3);
        end
        rec(3, {8'h00, pv, 8'h40, 8'h84}, 4, meter.pulse_a);
        rec(4, {pv, 8'h40, 8'h80, 8'h84}, 4, meter.pulse_b);
        // operating hours and info in the basic format
        if (!fmt_ext)
        begin
            rec(2, 32'h0000_2204, 4, meter.op_hours);
            rec(3, 32'h0017_FD04, 4, inf);
        end
    endtask

    // Load a meter snapshot pattern with chosen coding options
    task automatic setup(input logic [31:0] s, input logic vife, input logic nrg, input logic wide);
        logic [447:0]        w;
        ppf_pkg::ppf_meter_t m;
        w                 = {14{s}};
        m                 = w[$bits(ppf_pkg::ppf_meter_t)-1:0];
        m.energy_vife_en  = vife;
        m.pulse_is_energy = nrg;
        m.info_wide       = wide;
        // One assignment, so the meter bus changes once per edge
        meter <= m;
        @(posedge clk_sys);
    endtask

    // One message; a start while busy and a meter change must both be ignored
    task automatic run_msg(input logic ext, input logic pace);
        int                 n1;
        int                 k;
        ppf_pkg::ppf_byte_t exp_b;
        fmt_ext <= ext;
        slow    <= pace;
        start   <= 1'b1;
        got_q.delete();
        @(posedge clk_sys);
        build_exp(n1);
        for (k = 0; k < 8 && busy !== 1'b1; k++)
            @(posedge clk_sys);
        if (k == 8)
            timeout();
        start <= 1'b0;
        repeat (5) @(posedge clk_sys);
        start        <= 1'b1;
        meter.energy <= ~meter.energy;
        @(posedge clk_sys);
        start <= 1'b0;
        for (k = 0; k < 2000 && busy !== 1'b0; k++)
            @(posedge clk_sys);
        for (k = 0; k < 20 && (busy !== 1'b0 || tx_valid !== 1'b0); k++)
            @(posedge clk_sys);
        if (k == 20)
            timeout();
        check(got_q.size(), exp_q.size());
        for (int i = 0; i < got_q.size() && i < exp_q.size(); i++)
        begin
            exp_b = {exp_q[i], i == 0 || i == n1, i == n1 - 1 || i == exp_q.size() - 1, i >= n1};
            check({21'h0, got_q[i]}, {21'h0, exp_b});
        end
    endtask

    // ========================================================================
    // Scenarios
    task automatic t_basic_volume;
        setup(32'h1234_5678, 1'b0, 1'b0, 1'b0);
        run_msg(1'b0, 1'b0);
    endtask

    task automatic t_ext_energy_slow;
        setup(32'h89AB_CDEF, 1'b1, 1'b1, 1'b1);
        run_msg(1'b1, 1'b1);
    endtask

    task automatic t_basic_energy_slow;
        setup(32'h0F1E_2D3C, 1'b1, 1'b1, 1'b0);
        run_msg(1'b0, 1'b1);
    endtask

    task automatic t_ext_volume;
        setup(32'hC3A5_9617, 1'b0, 1'b0, 1'b0);
        run_msg(1'b1, 1'b0);
    endtask

    // Reset in mid-message must idle the block, then a fresh message runs
    task automatic t_reset_mid;
        setup(32'h5A5A_0FF0, 1'b0, 1'b0, 1'b1);
        fmt_ext <= 1'b0;
        slow    <= 1'b0;
        start   <= 1'b1;
        repeat (10) @(posedge clk_sys);
        start <= 1'b0;
        rst_n <= 1'b0;
        repeat (3) @(posedge clk_sys);
        check({30'h0, busy, tx_valid}, 32'h0000_0000);
        check({21'h0, tx_byte}, 32'h0000_0000);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk_sys);
        run_msg(1'b0, 1'b0);
    endtask

    // ========================================================================
    // Main sequence
    initial
    begin
        repeat (3) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk_sys);
        t_basic_volume();
        t_ext_energy_slow();
        t_basic_energy_slow();
        t_ext_volume();
        t_reset_mid();
        test_done();
    end
endmodule // tb

`default_nettype wire
